// *** logic/seb_consts.vh ***
// constants for the two-wire eeprom target: address word layout, timing counts
// assumes a 20 MHz core clock; bus clock sampled, never used as a clock
`ifndef SEB_CONSTS_VH
`define SEB_CONSTS_VH

// ----------------------------------------------------------------
// address word
// ----------------------------------------------------------------
`define SEB_TYPE_CODE      4'h5
`define SEB_MEM_DEPTH      256
`define SEB_ADDR_W         8

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SEB_CLK_HZ         20000000
`define SEB_WRITE_TIME_MS  5
`define SEB_WRITE_CYCLES   ((`SEB_CLK_HZ / 1000) * `SEB_WRITE_TIME_MS)

`endif

// *** logic/seb_eeprom_slave.v ***
// two-wire serial eeprom target: 256 x 8 array, chip-select straps, write protect
// assumes scl/sda/straps/wp arrive asynchronously; sda pin resolved outside
// Function
// - sample on clock rise, drive after fall
// - data pin open drain, low or released
// - respond only when select bits match straps
// - write protect high blocks all array writes
// - protected: still ack address and memory address
// - protected: nack each data byte, no write
// - unprotected: all locations writable
// - reads work regardless of write protect
// - internal write finishes within 5 ms
// - address word: type, three select, direction
// - receiver pulls data low on ninth clock
// - ignore bus during internal write cycle
`timescale 1ns/1ps
`include "seb_consts.vh"

module seb_eeprom_slave
#(
    parameter [3:0]  TYPE_CODE    = `SEB_TYPE_CODE,  // arbitrary value
    parameter [31:0] WRITE_CYCLES = `SEB_WRITE_CYCLES
)
(
    // clock and reset
    input  wire        clock_in,
    input  wire        arst_n_in,
    // bus pins
    input  wire        scl_in,
    input  wire        sda_in,
    output wire        sda_out,
    output wire        sda_oe_n_out,
    // straps and protect
    input  wire        chip_select_bit0_in,
    input  wire        chip_select_bit1_in,
    input  wire        chip_select_bit2_in,
    input  wire        write_protect_in,
    // status
    output reg         busy_out
);

    // ----------------------------------------------------------------
    // reset and input synchronisers
    // ----------------------------------------------------------------
    reg        rst_a_reg;
    reg        rst_n_reg;
    reg  [5:0] sync1_reg;
    reg  [5:0] sync2_reg;
    wire       rst_n = rst_n_reg;

    always @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            rst_a_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end
        else
        begin
            rst_a_reg <= 1'b1;
            rst_n_reg <= rst_a_reg;
        end
    end

    always @(posedge clock_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_reg <= 6'h03;
            sync2_reg <= 6'h03;
        end
        else
        begin
            sync1_reg <= {write_protect_in, chip_select_bit2_in, chip_select_bit1_in,
                          chip_select_bit0_in, sda_in, scl_in};
            sync2_reg <= sync1_reg;
        end
    end

    wire       scl_s = sync2_reg[0];
    wire       sda_s = sync2_reg[1];
    wire [2:0] straps = sync2_reg[4:2];
    wire       wp_s = sync2_reg[5];

    reg  scl_d_reg;
    reg  sda_d_reg;
    wire scl_rise = scl_s & ~scl_d_reg;
    wire scl_fall = ~scl_s & scl_d_reg;
    // edges of data while clock is high mark start and stop
    wire start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    wire stop_cond = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

    // ----------------------------------------------------------------
    // states
    // ----------------------------------------------------------------
    localparam [6:0] ST_IDLE = 7'h01;
    localparam [6:0] ST_DEV  = 7'h02;
    localparam [6:0] ST_MADR = 7'h04;
    localparam [6:0] ST_WDAT = 7'h08;
    localparam [6:0] ST_RDAT = 7'h10;
    localparam [6:0] ST_RACK = 7'h20;
    localparam [6:0] ST_PROG = 7'h40;

    reg  [6:0]  state_reg;
    reg  [3:0]  bit_cnt_reg;
    reg  [7:0]  shift_reg;
    reg  [7:0]  addr_reg;
    reg         ack_phase_reg;
    reg         ack_low_reg;
    reg         drive_low_reg;
    reg         wp_seen_reg;
    reg  [31:0] prog_cnt_reg;
    reg  [7:0]  mem_reg [0:`SEB_MEM_DEPTH-1];
    reg         fill_reg [0:`SEB_MEM_DEPTH-1];
    reg  [7:0]  page_reg [0:`SEB_MEM_DEPTH-1];
    reg         any_fill_reg;

    // ----------------------------------------------------------------
    // two-entry buffer between byte receiver and page latch
    // ----------------------------------------------------------------
    reg  [15:0] buf_data_reg [0:1];
    reg         buf_wr_reg;
    reg         buf_rd_reg;
    reg  [1:0]  buf_cnt_reg;
    wire        buf_in_valid;
    wire        buf_in_ready = (buf_cnt_reg != 2'h2);
    wire        buf_out_valid = (buf_cnt_reg != 2'h0);
    // page latch drains one entry a cycle, but stalls during programming
    wire        buf_out_ready = (state_reg != ST_PROG);
    wire [15:0] buf_out_data = buf_data_reg[buf_rd_reg];

    // ----------------------------------------------------------------
    // protocol engine
    // ----------------------------------------------------------------
    wire byte_done = scl_rise & ~ack_phase_reg & (bit_cnt_reg == 4'h7);
    wire [7:0] rx_byte = {shift_reg[6:0], sda_s};
    assign buf_in_valid = byte_done & (state_reg == ST_WDAT) & ~wp_s;
    integer i;

    always @(posedge clock_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            addr_reg <= 8'h00;
            ack_phase_reg <= 1'b0;
            ack_low_reg <= 1'b0;
            drive_low_reg <= 1'b0;
            wp_seen_reg <= 1'b0;
            prog_cnt_reg <= 32'h0;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
            busy_out <= 1'b0;
            buf_wr_reg <= 1'b0;
            buf_rd_reg <= 1'b0;
            buf_cnt_reg <= 2'h0;
            any_fill_reg <= 1'b0;
            buf_data_reg[0] <= 16'h0000;
            buf_data_reg[1] <= 16'h0000;
            for (i = 0; i < `SEB_MEM_DEPTH; i = i + 1)
            begin
                mem_reg[i] <= 8'hFF;
                fill_reg[i] <= 1'b0;
                page_reg[i] <= 8'h00;
            end
        end
        else
        begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
            // buffer bookkeeping
            if (buf_in_valid & buf_in_ready)
            begin
                buf_data_reg[buf_wr_reg] <= {addr_reg, rx_byte};
                buf_wr_reg <= ~buf_wr_reg;
            end
            if (buf_out_valid & buf_out_ready)
            begin
                page_reg[buf_out_data[15:8]] <= buf_out_data[7:0];
                fill_reg[buf_out_data[15:8]] <= 1'b1;
                any_fill_reg <= 1'b1;
                buf_rd_reg <= ~buf_rd_reg;
            end
            buf_cnt_reg <= buf_cnt_reg + {1'b0, buf_in_valid & buf_in_ready}
                           - {1'b0, buf_out_valid & buf_out_ready};

            if (state_reg == ST_PROG)
            begin
                // bus inputs ignored until the self-timed write ends
                if (prog_cnt_reg >= WRITE_CYCLES - 32'h1)
                begin
                    for (i = 0; i < `SEB_MEM_DEPTH; i = i + 1)
                    begin
                        if (fill_reg[i])
                            mem_reg[i] <= page_reg[i];
                        fill_reg[i] <= 1'b0;
                    end
                    any_fill_reg <= 1'b0;
                    busy_out <= 1'b0;
                    state_reg <= ST_IDLE;
                end
                else
                    prog_cnt_reg <= prog_cnt_reg + 32'h1;
            end
            else if (stop_cond)
            begin
                drive_low_reg <= 1'b0;
                ack_phase_reg <= 1'b0;
                if (state_reg == ST_WDAT & (any_fill_reg | buf_out_valid) & ~wp_seen_reg)
                begin
                    state_reg <= ST_PROG;
                    prog_cnt_reg <= 32'h0;
                    busy_out <= 1'b1;
                end
                else
                    state_reg <= ST_IDLE;
            end
            else if (start_cond)
            begin
                state_reg <= ST_DEV;
                bit_cnt_reg <= 4'h0;
                ack_phase_reg <= 1'b0;
                drive_low_reg <= 1'b0;
            end
            else if (state_reg != ST_IDLE)
            begin
                if (scl_rise)
                begin
                    if (ack_phase_reg)
                    begin
                        ack_phase_reg <= 1'b0;
                        bit_cnt_reg <= 4'h0;
                        if (state_reg == ST_RACK & sda_s)
                            state_reg <= ST_IDLE;  // master nack ends the read
                        else if (state_reg == ST_RACK)
                            state_reg <= ST_RDAT;
                    end
                    else
                    begin
                        shift_reg <= rx_byte;
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        if (byte_done)
                        begin
                            ack_phase_reg <= 1'b1;
                            ack_low_reg <= 1'b0;
                            case (state_reg)
                                ST_DEV:
                                begin
                                    if (rx_byte[7:4] == TYPE_CODE
                                        & rx_byte[3:1] == straps)
                                    begin
                                        ack_low_reg <= 1'b1;
                                        wp_seen_reg <= 1'b0;
                                        state_reg <= rx_byte[0] ? ST_RACK : ST_MADR;
                                        if (rx_byte[0])
                                            shift_reg <= mem_reg[addr_reg];
                                    end
                                    else
                                        state_reg <= ST_IDLE;
                                end
                                ST_MADR:
                                begin
                                    addr_reg <= rx_byte;
                                    ack_low_reg <= 1'b1;
                                    state_reg <= ST_WDAT;
                                end
                                ST_WDAT:
                                begin
                                    if (wp_s)
                                        wp_seen_reg <= 1'b1;
                                    else if (buf_in_ready)
                                    begin
                                        ack_low_reg <= 1'b1;
                                        addr_reg <= {addr_reg[7:4], addr_reg[3:0] + 4'h1};
                                    end
                                end
                                ST_RDAT:
                                begin
                                    addr_reg <= addr_reg + 8'h01;
                                    state_reg <= ST_RACK;
                                    shift_reg <= mem_reg[addr_reg + 8'h01];
                                end
                                default:
                                    state_reg <= ST_IDLE;
                            endcase
                        end
                    end
                end
                if (scl_fall)
                begin
                    if (ack_phase_reg)
                        drive_low_reg <= ack_low_reg & (state_reg != ST_RACK | bit_cnt_reg == 4'h8);
                    else if (state_reg == ST_RDAT | (state_reg == ST_RACK & bit_cnt_reg != 4'h8))
                        // shift_reg moves left on each data-bit rise and reloads at byte end, so its msb is always the next bit
                        drive_low_reg <= ~shift_reg[7];
                    else
                        drive_low_reg <= 1'b0;
                end
            end
            else
                drive_low_reg <= 1'b0;
        end
    end

    // open drain: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe_n_out = ~drive_low_reg;

endmodule

// *** verification/seb_eeprom_slave_sva.sv ***
// checker: data pin timing and write cycle length of the eeprom target
// sees only the target's top ports; bound from the testbench top
`timescale 1ns/1ps
module seb_eeprom_slave_sva
#(
    parameter [31:0] WRITE_CYCLES = 32'h32
)
(
    input wire clock_in,
    input wire arst_n_in,
    input wire scl_in,
    input wire sda_in,
    input wire sda_out,
    input wire sda_oe_n_out,
    input wire chip_select_bit0_in,
    input wire chip_select_bit1_in,
    input wire chip_select_bit2_in,
    input wire write_protect_in,
    input wire busy_out
);
    // ------------------------------------------------------------
    // consecutive busy cycles
    // ------------------------------------------------------------
    reg [31:0] busy_cnt_reg;
    always @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            busy_cnt_reg <= 32'h0;
        else
            busy_cnt_reg <= busy_out ? busy_cnt_reg + 32'h1 : 32'h0;
    end
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!arst_n_in);
    drive_zero_a: assert property (sda_out == 1'b0) else $error("pin value not low");
    hold_high_a: assert property (scl_in && $past(scl_in) && $past(scl_in, 2)
        |-> $stable(sda_oe_n_out)) else $error("drive changed with clock high");
    pull_low_a: assert property ($fell(sda_oe_n_out) |-> !scl_in)
        else $error("pull started with clock high");
    release_low_a: assert property ($rose(sda_oe_n_out) |-> !scl_in)
        else $error("release with clock high");
    busy_quiet_a: assert property (busy_out |-> sda_oe_n_out) else $error("drive while busy");
    busy_stop_a: assert property ($rose(busy_out) |-> scl_in && sda_in)
        else $error("busy without stop");
    busy_bound_a: assert property (busy_out |-> busy_cnt_reg < WRITE_CYCLES)
        else $error("write cycle too long");
    busy_len_a: assert property ($fell(busy_out) |-> busy_cnt_reg == WRITE_CYCLES)
        else $error("write cycle length wrong");
endmodule

// *** verification/seb_bus_master_model.sv ***
// bus master model: clock high 3 cycles, low 5, so the target's lag fits
// assumes the bench resolves the data wire with a pull-up
`timescale 1ns/1ps
module seb_bus_master_model
(
    input  wire        clock_in,
    input  wire        sda_in,
    output logic       scl_out,
    output logic       sda_rel_out,
    output logic       res_stb_out,
    output logic [7:0] res_out
);
    initial
    begin
        scl_out = 1'b1;
        sda_rel_out = 1'b1;
        res_stb_out = 1'b0;
        res_out = 8'h00;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock_in) #1;
    endtask
    task automatic start();
        sda_rel_out = 1'b1;
        tick(3);
        scl_out = 1'b1;
        tick(3);
        sda_rel_out = 1'b0;
        tick(3);
        scl_out = 1'b0;
        tick(3);
    endtask
    task automatic stop();
        sda_rel_out = 1'b0;
        tick(3);
        scl_out = 1'b1;
        tick(3);
        sda_rel_out = 1'b1;
        tick(8);
    endtask
    // reads send 8'hFF so the line stays released for the target
    task automatic byte_io(input logic [7:0] d, input logic b9, input logic rd);
        logic [8:0] got;
        for (int i = 8; i >= 0; i--)
        begin
            sda_rel_out = (i == 0) ? b9 : d[i-1];
            tick(2);
            scl_out = 1'b1;
            tick(3);
            got[i] = sda_in;
            scl_out = 1'b0;
            tick(3);
        end
        res_out = rd ? got[8:1] : {7'h00, got[0]};
        res_stb_out = 1'b1;
        tick(1);
        res_stb_out = 1'b0;
    endtask
endmodule

// *** verification/seb_eeprom_slave_tb.sv ***
// testbench: select match, protected and open writes, reads, busy window
// drives the target through the master model; results checked via a queue
`timescale 1ns/1ps
`include "seb_consts.vh"
`define CHK(e, g, n) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module seb_eeprom_slave_tb;
    logic       clock_in = 1'b0;
    logic       arst_n_in = 1'b0;
    logic       wp = 1'b0;
    logic [2:0] sel = 3'h0;
    logic [7:0] a0, a1, d0, d1, d2, exp_v;
    logic [7:0] exp_q[$];
    int         err_total = 0;
    int         cmp_count = 0;
    wire        scl, rel, stb, oe_n, dout, busy;
    wire [7:0]  res;
    wire        sda = rel & (oe_n ? 1'b1 : dout);
    always #25 clock_in = ~clock_in;
    seb_eeprom_slave #(.WRITE_CYCLES(32'h32)) i_seb_eeprom_slave (.clock_in(clock_in),
        .arst_n_in(arst_n_in), .scl_in(scl), .sda_in(sda), .sda_out(dout),
        .sda_oe_n_out(oe_n), .chip_select_bit0_in(sel[0]), .chip_select_bit1_in(sel[1]),
        .chip_select_bit2_in(sel[2]), .write_protect_in(wp), .busy_out(busy));
    seb_bus_master_model i_seb_bus_master_model (.clock_in(clock_in), .sda_in(sda),
        .scl_out(scl), .sda_rel_out(rel), .res_stb_out(stb), .res_out(res));
    always @(posedge clock_in)
    begin
        if (stb === 1'b1)
        begin
            exp_v = exp_q.pop_front();
            `CHK(exp_v, res, "bus result")
        end
    end
    task automatic report_and_stop();
        if (err_total == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wb(input logic [7:0] d, input logic ack);
        exp_q.push_back({7'h00, ack});
        i_seb_bus_master_model.byte_io(d, 1'b1, 1'b0);
    endtask
    task automatic aw(input logic [2:0] s, input logic rw, input logic ack);
        i_seb_bus_master_model.start();
        wb({`SEB_TYPE_CODE, s, rw}, ack);
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 200)
        begin
            @(posedge clock_in) #1;
            n++;
        end
        if (n == 200)
            err_total++;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e[3], input int cnt);
        aw(sel, 1'b0, 1'b0);
        wb(a, 1'b0);
        aw(sel, 1'b1, 1'b0);
        for (int i = 0; i < cnt; i++)
        begin
            exp_q.push_back(e[i]);
            i_seb_bus_master_model.byte_io(8'hFF, i == cnt - 1, 1'b1);
        end
        i_seb_bus_master_model.stop();
    endtask
    initial
    begin
        #4000000;
        err_total++;
        report_and_stop();
    end
    initial
    begin
        void'($urandom(32'hd677d668));
        repeat (10) @(posedge clock_in);
        #1;
        arst_n_in = 1'b1;
        sel = 3'($urandom);
        a0 = {4'($urandom), 4'h0};
        a1 = {a0[7:4] ^ 4'h1, 4'h8};
        d0 = 8'($urandom);
        d1 = 8'($urandom);
        d2 = 8'($urandom);
        repeat (8) @(posedge clock_in) #1;
        for (int k = 0; k < 8; k++)
        begin
            aw(3'(k), 1'b0, 3'(k) != sel);
            i_seb_bus_master_model.stop();
            wait_idle();
        end
        aw(sel, 1'b0, 1'b0);
        wb(a0, 1'b0);
        wb(d0, 1'b0);
        i_seb_bus_master_model.stop();
        aw(sel, 1'b0, 1'b1);
        i_seb_bus_master_model.stop();
        wait_idle();
        aw(sel, 1'b0, 1'b0);
        wb(a1, 1'b0);
        wb(d1, 1'b0);
        wb(d2, 1'b0);
        i_seb_bus_master_model.stop();
        wait_idle();
        wp = 1'b1;
        aw(sel, 1'b0, 1'b0);
        wb(a0, 1'b0);
        wb(~d0, 1'b1);
        i_seb_bus_master_model.stop();
        wait_idle();
        rd(a0, '{d0, 8'h00, 8'h00}, 1);
        rd(a1, '{d1, d2, 8'hFF}, 3);
        report_and_stop();
    end
endmodule
bind seb_eeprom_slave seb_eeprom_slave_sva #(.WRITE_CYCLES(WRITE_CYCLES)) i_seb_eeprom_slave_sva
    (.clock_in(clock_in), .arst_n_in(arst_n_in), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out), .chip_select_bit0_in(chip_select_bit0_in),
    .chip_select_bit1_in(chip_select_bit1_in), .chip_select_bit2_in(chip_select_bit2_in),
    .write_protect_in(write_protect_in), .busy_out(busy_out));
